//--- hdl/scmh_cfg.svh
// Purpose: constants for the core message handler
// Assumes: included by bare name
// Notes: message codes are the 7-bit core codes
`ifndef SCMH_CFG_SVH
`define SCMH_CFG_SVH
`define SCMH_MC_REPORT_PRESENT 7'h01
`define SCMH_MC_ASSIGN_LA 7'h02
`define SCMH_MC_RESET_DEVICE 7'h04
`define SCMH_MC_CHANGE_LA 7'h08
`define SCMH_MC_REQ_SELF_ANN 7'h0c
`define SCMH_MC_REQ_INFO 7'h20
`define SCMH_MC_REQ_CLR_INFO 7'h21
`define SCMH_MC_REPLY_INFO 7'h24
`define SCMH_MC_CLR_INFO 7'h28
`define SCMH_MC_REPORT_INFO 7'h29
`define SCMH_MC_BEGIN_RECFG 7'h40
`define SCMH_MC_NEXT_FRAMER 7'h44
`define SCMH_MC_NEXT_SM 7'h45
`define SCMH_MC_NEXT_CG 7'h46
`define SCMH_MC_NEXT_RF 7'h47
`define SCMH_MC_NEXT_PAUSE 7'h4a
`define SCMH_MC_NEXT_RST_BUS 7'h4b
`define SCMH_MC_NEXT_SHUTDOWN 7'h4c
`define SCMH_MC_RECFG_NOW 7'h5f
`define SCMH_MC_REQ_VALUE 7'h60
`define SCMH_MC_REPLY_VALUE 7'h64
`define SCMH_MC_CHANGE_VALUE 7'h68
`define SCMH_CELLS_PER_SLOT 4
`define SCMH_SLOTS_PER_FRAME 192
`define SCMH_FRAMES_PER_SF 8
`define SCMH_SETTLE_SLOTS 2'h2
`define SCMH_MAP_BLOCK_BYTES 1024
`define SCMH_MAP_BLOCKS 3
`define SCMH_USER_VAL_BASE 12'h800
`define SCMH_INFO_EVT_EC 12'h400
`define SCMH_RST_SM 5'h00
`define SCMH_RST_CG 4'ha
`define SCMH_RST_RF 4'h1
`endif

//--- hdl/scmh_core_msg_handler.sv
// Purpose: device-side interpreter of core bus control messages
// Assumes: message layer decodes fields and flags dest_hit for our LA, EA or broadcast
// Notes: one reply in flight; requests are held off with rx_ready_out meanwhile
// Notes on behaviour
// - no join request before frame sync
// - announce class and version, also on request
// - assigned address adopted, device then enumerated
// - enumerated device accepts address change anytime
// - device reset resets ports and channels
// - interface reset resets component, releases address
// - information map of three kilobyte blocks
// - information reply echoes transaction id
// - clear-request replies then clears masked bits
// - clear clears masked bits, no reply
// - information change sends report with value
// - value map of three kilobyte blocks
// - value reply echoes id with contents
// - value change writes element
// - staged parameters apply together at boundary
// - apply at superframe two slots after
// - begin and now carry no payload
// - framer handover address and idle counts
// - subframe mode and gear staged, applied
// - pause halts bus clock with restart
// - bus reset disconnects, rejoin as start-up
// - four cells, 192 slots, eight frames
`timescale 1ns/100ps
`default_nettype none
`include "scmh_cfg.svh"
module scmh_core_msg_handler #(
  parameter logic [7:0] DEV_CLASS = 8'h00,
  parameter logic [7:0] DEV_CLASS_VER = 8'h01,
  parameter bit IS_IFACE = 1'b1
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic bus_clk_in,
  input wire logic sf_start_in,
  input wire logic frame_synced_in,
  input wire scmh_pkg::scmh_rx_t rx_in,
  output logic rx_ready_out,
  output scmh_pkg::scmh_tx_t tx_out,
  input wire logic tx_ready_in,
  input wire logic info_evt_in,
  input wire logic [7:0] info_evt_mask_in,
  output logic [7:0] la_out,
  output logic enumerated_out,
  output scmh_pkg::scmh_frame_cfg_t frame_cfg_out,
  output scmh_pkg::scmh_handover_t handover_out,
  output logic pause_out,
  output logic [7:0] pause_rt_out,
  output logic shutdown_out,
  output logic port_reset_out,
  output logic comp_reset_out,
  output scmh_pkg::scmh_reg_wr_t reg_wr_out
);
  import scmh_pkg::*;

  function automatic logic mc_is(input scmh_rx_t m, input logic [6:0] code);
    return m.mc == code;
  endfunction : mc_is

  ////////////////////////////////////////////////////////////////////////////
  scmh_enum_state_t st_ff;
  scmh_tx_t tx_ff;
  scmh_frame_cfg_t stg_ff;
  scmh_handover_t stg_ho_ff;
  logic [7:0] stg_rt_ff;
  logic [6:0] pend_mc_ff;
  logic [7:0] pend_tid_ff, pend_or_ff, evt_mask_ff;
  logic [11:0] pend_ec_ff;
  logic pend_ff, pend_val_ff;
  logic open_ff, armed_ff, shut_ff;
  logic s_sm_ff, s_cg_ff, s_rf_ff, s_ho_ff, s_pause_ff, s_rst_ff, s_shut_ff;
  logic [1:0] wait_ff;
  logic [7:0] info_rd, val_rd;
  logic slot_tick, sf_bnd, acc, evt_go, info_en, val_en, ann_go, apply, wipe, dev_rst;

  scmh_slot_timer u_timer (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .bus_clk_in(bus_clk_in),
    .sf_start_in(sf_start_in),
    .slot_tick_out(slot_tick),
    .sf_bnd_out(sf_bnd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // a request is taken only while the reply path is free, so no reply is lost
  assign rx_ready_out = ~pend_ff & ~tx_ff.valid;
  assign acc = rx_in.valid & rx_ready_out & rx_in.dest_hit;
  assign dev_rst = acc & mc_is(rx_in, `SCMH_MC_RESET_DEVICE);
  assign apply = armed_ff & (wait_ff == 2'h0) & sf_bnd;
  assign wipe = (dev_rst & IS_IFACE) | (apply & s_rst_ff);

  assign info_en = acc & (mc_is(rx_in, `SCMH_MC_REQ_INFO) | mc_is(rx_in, `SCMH_MC_REQ_CLR_INFO)
                   | mc_is(rx_in, `SCMH_MC_CLR_INFO));
  assign val_en = acc & (mc_is(rx_in, `SCMH_MC_REQ_VALUE) | mc_is(rx_in, `SCMH_MC_CHANGE_VALUE));
  // events wait while a message owns the map; their bits stay sticky
  assign evt_go = rx_ready_out & ~acc & (evt_mask_ff != 8'h00) & ~shut_ff;
  assign ann_go = (st_ff == SCMH_ANNOUNCE) & frame_synced_in & ~pend_ff & ~tx_ff.valid
                  & ~acc & ~evt_go & ~shut_ff;

  scmh_elem_map u_info (
    .core_clk_in(core_clk_in),
    .en_in(info_en | evt_go),
    .addr_in(info_en ? rx_in.ec : `SCMH_INFO_EVT_EC),
    .wr_en_in(1'b0),
    .wr_data_in(8'h00),
    .clr_mask_in(info_en & ~mc_is(rx_in, `SCMH_MC_REQ_INFO) ? rx_in.byte0 : 8'h00),
    .set_mask_in(info_en ? 8'h00 : evt_mask_ff),
    .rd_data_out(info_rd)
  );

  scmh_elem_map u_value (
    .core_clk_in(core_clk_in),
    .en_in(val_en),
    .addr_in(rx_in.ec),
    .wr_en_in(mc_is(rx_in, `SCMH_MC_CHANGE_VALUE)),
    .wr_data_in(rx_in.byte0),
    .clr_mask_in(8'h00),
    .set_mask_in(8'h00),
    .rd_data_out(val_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sticky event bits: a new event in the serviced cycle is kept
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      evt_mask_ff <= 8'h00;
    end else begin
      evt_mask_ff <= (evt_go ? 8'h00 : evt_mask_ff) | (info_evt_in ? info_evt_mask_in : 8'h00);
    end
  end

  // pending read: the map answers one cycle after the access
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_ff <= 1'b0;
      pend_val_ff <= 1'b0;
      pend_mc_ff <= 7'h00;
      pend_tid_ff <= 8'h00;
      pend_ec_ff <= 12'h000;
      pend_or_ff <= 8'h00;
    end else if (pend_ff) begin
      pend_ff <= 1'b0;
    end else if (acc & (mc_is(rx_in, `SCMH_MC_REQ_INFO) | mc_is(rx_in, `SCMH_MC_REQ_CLR_INFO))) begin
      pend_ff <= 1'b1;
      pend_val_ff <= 1'b0;
      pend_mc_ff <= `SCMH_MC_REPLY_INFO;
      pend_tid_ff <= rx_in.tid;
      pend_ec_ff <= rx_in.ec;
      pend_or_ff <= 8'h00;
    end else if (acc & mc_is(rx_in, `SCMH_MC_REQ_VALUE)) begin
      pend_ff <= 1'b1;
      pend_val_ff <= 1'b1;
      pend_mc_ff <= `SCMH_MC_REPLY_VALUE;
      pend_tid_ff <= rx_in.tid;
      pend_ec_ff <= rx_in.ec;
      pend_or_ff <= 8'h00;
    end else if (evt_go) begin
      pend_ff <= 1'b1;
      pend_val_ff <= 1'b0;
      pend_mc_ff <= `SCMH_MC_REPORT_INFO;
      pend_tid_ff <= 8'h00;
      pend_ec_ff <= `SCMH_INFO_EVT_EC;
      pend_or_ff <= evt_mask_ff;
    end
  end

  // outgoing message register
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_ff <= '0;
    end else if (shut_ff | wipe) begin
      tx_ff <= '0;
    end else if (tx_ff.valid) begin
      if (tx_ready_in) begin
        tx_ff.valid <= 1'b0;
      end
    end else if (pend_ff) begin
      tx_ff.valid <= 1'b1;
      tx_ff.mc <= pend_mc_ff;
      tx_ff.tid <= pend_tid_ff;
      tx_ff.ec <= pend_ec_ff;
      tx_ff.data <= (pend_val_ff ? val_rd : info_rd) | pend_or_ff;
      tx_ff.aux <= 8'h00;
    end else if (ann_go) begin
      tx_ff.valid <= 1'b1;
      tx_ff.mc <= `SCMH_MC_REPORT_PRESENT;
      tx_ff.tid <= 8'h00;
      tx_ff.ec <= 12'h000;
      tx_ff.data <= DEV_CLASS;
      tx_ff.aux <= DEV_CLASS_VER;
    end
  end
  assign tx_out = tx_ff;

  ////////////////////////////////////////////////////////////////////////////
  // enumeration; is the manager's side and not checked here
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff <= SCMH_UNSYNC;
      la_out <= 8'h00;
    end else if (wipe | ~frame_synced_in) begin
      st_ff <= SCMH_UNSYNC;
      la_out <= 8'h00;
    end else begin
      case (st_ff)
        SCMH_UNSYNC: begin
          st_ff <= SCMH_ANNOUNCE;
        end
        SCMH_ANNOUNCE: begin
          if (ann_go) begin
            st_ff <= SCMH_WAIT_LA;
          end
        end
        SCMH_WAIT_LA: begin
          if (acc & mc_is(rx_in, `SCMH_MC_REQ_SELF_ANN)) begin
            st_ff <= SCMH_ANNOUNCE;
          end else if (acc & mc_is(rx_in, `SCMH_MC_ASSIGN_LA)) begin
            st_ff <= SCMH_ENUMERATED;
            la_out <= rx_in.byte0;
          end
        end
        SCMH_ENUMERATED: begin
          if (acc & mc_is(rx_in, `SCMH_MC_CHANGE_LA)) begin
            la_out <= rx_in.byte0;
          end
        end
        default: begin
          st_ff <= SCMH_UNSYNC;
        end
      endcase
    end
  end
  assign enumerated_out = (st_ff == SCMH_ENUMERATED);

  // reset pulses and register-map writes from the user value space
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_reset_out <= 1'b0;
      comp_reset_out <= 1'b0;
      reg_wr_out <= '0;
    end else begin
      port_reset_out <= dev_rst | wipe;
      comp_reset_out <= wipe;
      reg_wr_out.valid <= val_en & mc_is(rx_in, `SCMH_MC_CHANGE_VALUE) & (rx_in.ec >= `SCMH_USER_VAL_BASE);
      reg_wr_out.addr <= rx_in.ec - `SCMH_USER_VAL_BASE;
      reg_wr_out.data <= rx_in.byte0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reconfiguration staging; payload bytes of begin and now are ignored
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      open_ff <= 1'b0;
      armed_ff <= 1'b0;
      wait_ff <= 2'h0;
      stg_ff <= '0;
      stg_ho_ff <= '0;
      stg_rt_ff <= 8'h00;
      {s_sm_ff, s_cg_ff, s_rf_ff, s_ho_ff, s_pause_ff, s_rst_ff, s_shut_ff} <= 7'h00;
    end else if (wipe | apply) begin
      open_ff <= 1'b0;
      armed_ff <= 1'b0;
      {s_sm_ff, s_cg_ff, s_rf_ff, s_ho_ff, s_pause_ff, s_rst_ff, s_shut_ff} <= 7'h00;
    end else begin
      if (armed_ff & slot_tick & (wait_ff != 2'h0)) begin
        wait_ff <= wait_ff - 2'h1;
      end
      if (acc & mc_is(rx_in, `SCMH_MC_BEGIN_RECFG)) begin
        open_ff <= 1'b1;
        {s_sm_ff, s_cg_ff, s_rf_ff, s_ho_ff, s_pause_ff, s_rst_ff, s_shut_ff} <= 7'h00;
      end else if (acc & open_ff & mc_is(rx_in, `SCMH_MC_RECFG_NOW)) begin
        open_ff <= 1'b0;
        armed_ff <= 1'b1;
        wait_ff <= `SCMH_SETTLE_SLOTS;
      end else if (acc & open_ff) begin
        case (rx_in.mc)
          `SCMH_MC_NEXT_SM: begin
            s_sm_ff <= 1'b1;
            stg_ff.sm <= rx_in.byte0[4:0];
          end
          `SCMH_MC_NEXT_CG: begin
            s_cg_ff <= 1'b1;
            stg_ff.cg <= rx_in.byte0[3:0];
          end
          `SCMH_MC_NEXT_RF: begin
            s_rf_ff <= 1'b1;
            stg_ff.rf <= rx_in.byte0[3:0];
          end
          `SCMH_MC_NEXT_FRAMER: begin
            s_ho_ff <= 1'b1;
            stg_ho_ff <= {1'b1, rx_in.byte0, rx_in.byte1, rx_in.byte2};
          end
          `SCMH_MC_NEXT_PAUSE: begin
            s_pause_ff <= 1'b1;
            stg_rt_ff <= rx_in.byte0;
          end
          `SCMH_MC_NEXT_RST_BUS: begin
            s_rst_ff <= 1'b1;
          end
          `SCMH_MC_NEXT_SHUTDOWN: begin
            s_shut_ff <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // every staged item lands in the same cycle
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      frame_cfg_out <= {`SCMH_RST_SM, `SCMH_RST_CG, `SCMH_RST_RF};
      handover_out <= '0;
      pause_out <= 1'b0;
      pause_rt_out <= 8'h00;
      shut_ff <= 1'b0;
    end else begin
      handover_out.valid <= 1'b0;
      pause_out <= 1'b0;
      if (apply) begin
        if (s_sm_ff) frame_cfg_out.sm <= stg_ff.sm;
        if (s_cg_ff) frame_cfg_out.cg <= stg_ff.cg;
        if (s_rf_ff) frame_cfg_out.rf <= stg_ff.rf;
        if (s_ho_ff) handover_out <= stg_ho_ff;
        pause_out <= s_pause_ff;
        pause_rt_out <= stg_rt_ff;
        if (s_shut_ff) shut_ff <= 1'b1;
      end
    end
  end
  assign shutdown_out = shut_ff;

  ////////////////////////////////////////////////////////////////////////////
  property p_sync_first;
    @(posedge core_clk_in) disable iff (!nrst_in)
      (tx_out.valid && tx_out.mc == `SCMH_MC_REPORT_PRESENT) |-> $past(frame_synced_in);
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("present sent without sync");

  property p_present_class;
    @(posedge core_clk_in) disable iff (!nrst_in)
      $rose(tx_out.valid) && tx_out.mc == `SCMH_MC_REPORT_PRESENT |->
        tx_out.data == DEV_CLASS && tx_out.aux == DEV_CLASS_VER;
  endproperty
  a_present_class: assert property (p_present_class) else $error("present payload wrong");

  property p_assign_la;
    @(posedge core_clk_in) disable iff (!nrst_in)
      acc && st_ff == SCMH_WAIT_LA && mc_is(rx_in, `SCMH_MC_ASSIGN_LA) && frame_synced_in
      |=> enumerated_out && la_out == $past(rx_in.byte0);
  endproperty
  a_assign_la: assert property (p_assign_la) else $error("assigned address not adopted");

  property p_change_la;
    @(posedge core_clk_in) disable iff (!nrst_in)
      acc && enumerated_out && mc_is(rx_in, `SCMH_MC_CHANGE_LA) && frame_synced_in && !wipe
      |=> la_out == $past(rx_in.byte0);
  endproperty
  a_change_la: assert property (p_change_la) else $error("address change ignored");

  property p_comp_reset;
    @(posedge core_clk_in) disable iff (!nrst_in)
      dev_rst && IS_IFACE |=> comp_reset_out && port_reset_out && !enumerated_out && la_out == 8'h00;
  endproperty
  a_comp_reset: assert property (p_comp_reset) else $error("component reset incomplete");

  property p_info_reply;
    @(posedge core_clk_in) disable iff (!nrst_in)
      acc && mc_is(rx_in, `SCMH_MC_REQ_INFO) && !shut_ff ##1 !wipe && !shut_ff |=>
        tx_out.valid && tx_out.mc == `SCMH_MC_REPLY_INFO && tx_out.tid == $past(rx_in.tid, 2);
  endproperty
  a_info_reply: assert property (p_info_reply) else $error("information reply late or wrong id");

  property p_value_reply;
    @(posedge core_clk_in) disable iff (!nrst_in)
      acc && mc_is(rx_in, `SCMH_MC_REQ_VALUE) && !shut_ff ##1 !wipe && !shut_ff |=>
        tx_out.valid && tx_out.mc == `SCMH_MC_REPLY_VALUE && tx_out.tid == $past(rx_in.tid, 2);
  endproperty
  a_value_reply: assert property (p_value_reply) else $error("value reply late or wrong id");

  property p_boundary;
    @(posedge core_clk_in) disable iff (!nrst_in)
      apply |-> sf_bnd && wait_ff == 2'h0 && !$past(acc && mc_is(rx_in, `SCMH_MC_RECFG_NOW));
  endproperty
  a_boundary: assert property (p_boundary) else $error("applied off a valid boundary");

  property p_together;
    @(posedge core_clk_in) disable iff (!nrst_in)
      apply && s_sm_ff && s_cg_ff |=> frame_cfg_out.sm == $past(stg_ff.sm) && frame_cfg_out.cg == $past(stg_ff.cg);
  endproperty
  a_together: assert property (p_together) else $error("staged settings split");

  property p_quiet;
    @(posedge core_clk_in) disable iff (!nrst_in)
      shut_ff |-> !tx_out.valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("message after shutdown");

  property p_bus_reset;
    @(posedge core_clk_in) disable iff (!nrst_in)
      apply && s_rst_ff |=> !enumerated_out ##1 st_ff != SCMH_ENUMERATED;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset left device enumerated");
endmodule : scmh_core_msg_handler
`default_nettype wire

//--- hdl/scmh_elem_map.sv
// Purpose: one byte-wide element map of three one-kilobyte blocks
// Assumes: one access per cycle
// Notes: read returns the value before this cycle's update
`timescale 1ns/100ps
`default_nettype none
`include "scmh_cfg.svh"
module scmh_elem_map #(
  parameter int DEPTH = `SCMH_MAP_BLOCKS * `SCMH_MAP_BLOCK_BYTES
) (
  input wire logic core_clk_in,
  input wire logic en_in,
  input wire logic [11:0] addr_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] clr_mask_in,
  input wire logic [7:0] set_mask_in,
  output logic [7:0] rd_data_out
);
  logic [7:0] mem [0:DEPTH-1];
  // unmapped codes read zero and ignore updates
  always_ff @(posedge core_clk_in) begin
    if (en_in) begin
      if (32'(addr_in) < DEPTH) begin
        rd_data_out <= mem[addr_in];
        if (wr_en_in) begin
          mem[addr_in] <= wr_data_in;
        end else begin
          mem[addr_in] <= (mem[addr_in] & ~clr_mask_in) | set_mask_in;
        end
      end else begin
        rd_data_out <= 8'h00;
      end
    end
  end
endmodule : scmh_elem_map
`default_nettype wire

//--- hdl/scmh_pkg.sv
// Purpose: shared types of the core message handler
// Assumes: message layer delivers decoded fields
// Notes: none
package scmh_pkg;
  typedef enum logic [1:0] {
    SCMH_UNSYNC = 2'b00,
    SCMH_ANNOUNCE = 2'b01,
    SCMH_WAIT_LA = 2'b10,
    SCMH_ENUMERATED = 2'b11
  } scmh_enum_state_t;
  typedef struct packed {
    logic valid;
    logic dest_hit;
    logic [6:0] mc;
    logic [7:0] tid;
    logic [11:0] ec;
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } scmh_rx_t;
  typedef struct packed {
    logic valid;
    logic [6:0] mc;
    logic [7:0] tid;
    logic [11:0] ec;
    logic [7:0] data;
    logic [7:0] aux;
  } scmh_tx_t;
  typedef struct packed {
    logic [4:0] sm;
    logic [3:0] cg;
    logic [3:0] rf;
  } scmh_frame_cfg_t;
  typedef struct packed {
    logic valid;
    logic [7:0] la;
    logic [7:0] nco;
    logic [7:0] nci;
  } scmh_handover_t;
  typedef struct packed {
    logic valid;
    logic [11:0] addr;
    logic [7:0] data;
  } scmh_reg_wr_t;
endpackage : scmh_pkg

//--- hdl/scmh_slot_timer.sv
// Purpose: slot and superframe timing from the bus clock pin
// Assumes: sf_start_in is a core-clock pulse from frame sync logic
// Notes: bus clock must be well below half the core clock
`timescale 1ns/100ps
`default_nettype none
`include "scmh_cfg.svh"
module scmh_slot_timer (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic bus_clk_in,
  input wire logic sf_start_in,
  output logic slot_tick_out,
  output logic sf_bnd_out
);
  localparam int SF_SLOTS = `SCMH_SLOTS_PER_FRAME * `SCMH_FRAMES_PER_SF;
  logic sync1_ff, sync2_ff, sync3_ff;
  logic [1:0] cell_ff;
  logic [10:0] slot_ff;
  logic rise;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= bus_clk_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end
  assign rise = sync2_ff & ~sync3_ff;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cell_ff <= 2'h0;
      slot_ff <= 11'h000;
      slot_tick_out <= 1'b0;
      sf_bnd_out <= 1'b0;
    end else begin
      slot_tick_out <= 1'b0;
      sf_bnd_out <= 1'b0;
      if (sf_start_in) begin
        cell_ff <= 2'h0;
        slot_ff <= 11'h000;
        sf_bnd_out <= 1'b1;
      end else if (rise) begin
        cell_ff <= cell_ff + 2'h1;
        if (cell_ff == 2'(`SCMH_CELLS_PER_SLOT - 1)) begin
          slot_tick_out <= 1'b1;
          if (slot_ff == 11'(SF_SLOTS - 1)) begin
            slot_ff <= 11'h000;
            sf_bnd_out <= 1'b1;
          end else begin
            slot_ff <= slot_ff + 11'h001;
          end
        end
      end
    end
  end
endmodule : scmh_slot_timer
`default_nettype wire

//--- testbench/scmh_core_msg_handler_tb.sv
// Purpose: self-checking bench of the core message handler
// Assumes: inputs change 1 ns after the rising edge
// Notes: superframe boundaries come from sf_start pulses
`timescale 1ns/100ps
`default_nettype none
`include "scmh_cfg.svh"
module scmh_core_msg_handler_tb;
  import scmh_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, bclk, sf = 1'b0, synced = 1'b0, rx_rdy, tx_rdy, evt = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [7:0] evt_mask = 8'h05, la;
  logic enum_st, shut, pause, prst, crst;
  logic [7:0] rt;
  scmh_rx_t rx = '0;
  scmh_tx_t tx, txs;
  scmh_frame_cfg_t fcfg;
  scmh_handover_t ho;
  scmh_reg_wr_t rw, rws;
  int mismatches = 0, compares = 0;
  always #4 clk = ~clk;
  scmh_core_msg_handler u_dut (.core_clk_in(clk), .nrst_in(nrst), .bus_clk_in(bclk), .sf_start_in(sf),
    .frame_synced_in(synced), .rx_in(rx), .rx_ready_out(rx_rdy), .tx_out(tx), .tx_ready_in(tx_rdy),
    .info_evt_in(evt), .info_evt_mask_in(evt_mask), .la_out(la), .enumerated_out(enum_st),
    .frame_cfg_out(fcfg), .handover_out(ho), .pause_out(pause), .pause_rt_out(rt), .shutdown_out(shut),
    .port_reset_out(prst), .comp_reset_out(crst), .reg_wr_out(rw));
  scmh_mgr_model u_mgr (.clk_in(clk), .tx_valid_in(tx.valid), .lat_in(lat), .bus_clk_out(bclk),
    .tx_ready_out(tx_rdy));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic bail();
    mismatches++;
    $display("unexpected at %0t: wait ran out", $time);
    wrap_up();
  endtask : bail
  // request held until the edge that takes it; payload-free codes send zeros
  task automatic send(input logic [6:0] mc, input logic [7:0] tid, input logic [11:0] ec, input logic [7:0] b0);
    int n;
    for (n = 0; rx_rdy !== 1'b1 && n < 300; n++) step(1);
    if (n == 300) bail();
    rx = '{1'b1, 1'b1, mc, tid, ec, b0, 8'h00, 8'h00};
    step(1);
    rx.valid = 1'b0;
  endtask : send
  task automatic wait_tx();
    int n;
    for (n = 0; tx.valid !== 1'b1 && n < 300; n++) step(1);
    if (n == 300) bail();
    // the message stands unchanged until the edge that sees ready, so take it now
    txs = tx;
    for (n = 0; tx.valid === 1'b1 && n < 300; n++) step(1);
    if (n == 300) bail();
  endtask : wait_tx
  task automatic boundary();
    send(`SCMH_MC_RECFG_NOW, 8'h00, 12'h000, 8'h00);
    step(150);
    sf = 1'b1;
    step(1);
    sf = 1'b0;
  endtask : boundary
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_enum();
    step(20);
    check(tx.valid, 1'b0);
    synced = 1'b1;
    wait_tx();
    check({txs.mc, txs.data, txs.aux}, {`SCMH_MC_REPORT_PRESENT, 8'h00, 8'h01});
    send(`SCMH_MC_ASSIGN_LA, 8'h00, 12'h000, 8'h21);
    check({enum_st, la}, {1'b1, 8'h21});
    send(`SCMH_MC_CHANGE_LA, 8'h00, 12'h000, 8'h33);
    check(la, 8'h33);
    $display("test enum done");
  endtask : t_enum
  task automatic t_info();
    send(`SCMH_MC_CLR_INFO, 8'h00, 12'hbff, 8'hff);
    step(4);
    check(tx.valid, 1'b0);
    lat = 4'h5;
    send(`SCMH_MC_REQ_INFO, 8'h5a, 12'hbff, 8'h00);
    wait_tx();
    check({txs.mc, txs.tid, txs.data}, {`SCMH_MC_REPLY_INFO, 8'h5a, 8'h00});
    lat = 4'h0;
    send(`SCMH_MC_CLR_INFO, 8'h00, `SCMH_INFO_EVT_EC, 8'hff);
    evt = 1'b1;
    step(1);
    evt = 1'b0;
    wait_tx();
    check({txs.mc, txs.ec, txs.data}, {`SCMH_MC_REPORT_INFO, `SCMH_INFO_EVT_EC, 8'h05});
    send(`SCMH_MC_REQ_CLR_INFO, 8'h11, `SCMH_INFO_EVT_EC, 8'h01);
    wait_tx();
    check({txs.mc, txs.tid, txs.data}, {`SCMH_MC_REPLY_INFO, 8'h11, 8'h05});
    send(`SCMH_MC_REQ_INFO, 8'h12, `SCMH_INFO_EVT_EC, 8'h00);
    wait_tx();
    check({txs.tid, txs.data}, {8'h12, 8'h04});
    $display("test info done");
  endtask : t_info
  task automatic t_value();
    rws = '0;
    send(`SCMH_MC_CHANGE_VALUE, 8'h00, 12'h805, 8'ha5);
    repeat (3) begin
      if (rw.valid === 1'b1) rws = rw;
      step(1);
    end
    check({rws.valid, rws.addr, rws.data}, {1'b1, 12'h005, 8'ha5});
    send(`SCMH_MC_REQ_VALUE, 8'h77, 12'h805, 8'h00);
    wait_tx();
    check({txs.mc, txs.tid, txs.data}, {`SCMH_MC_REPLY_VALUE, 8'h77, 8'ha5});
    $display("test value done");
  endtask : t_value
  task automatic t_recfg();
    send(`SCMH_MC_BEGIN_RECFG, 8'h00, 12'h000, 8'h00);
    send(`SCMH_MC_NEXT_SM, 8'h00, 12'h000, 8'h03);
    send(`SCMH_MC_NEXT_CG, 8'h00, 12'h000, 8'h07);
    send(`SCMH_MC_RECFG_NOW, 8'h00, 12'h000, 8'h00);
    step(4);
    sf = 1'b1;
    step(1);
    sf = 1'b0;
    step(3);
    check(fcfg, {`SCMH_RST_SM, `SCMH_RST_CG, `SCMH_RST_RF});
    step(150);
    sf = 1'b1;
    step(1);
    sf = 1'b0;
    step(2);
    check(fcfg, {5'h03, 4'h7, `SCMH_RST_RF});
    $display("test recfg done");
  endtask : t_recfg
  task automatic t_reset();
    logic seen;
    seen = 1'b0;
    send(`SCMH_MC_RESET_DEVICE, 8'h00, 12'h000, 8'h00);
    repeat (3) begin
      seen = seen | (crst === 1'b1 && prst === 1'b1);
      step(1);
    end
    check({seen, enum_st, la}, {1'b1, 1'b0, 8'h00});
    $display("test reset done");
  endtask : t_reset
  task automatic t_ctrl();
    logic hov, pz;
    hov = 1'b0;
    pz = 1'b0;
    wait_tx();
    check(txs.mc, `SCMH_MC_REPORT_PRESENT);
    send(`SCMH_MC_ASSIGN_LA, 8'h00, 12'h000, 8'h21);
    send(`SCMH_MC_BEGIN_RECFG, 8'h00, 12'h000, 8'h00);
    send(`SCMH_MC_NEXT_FRAMER, 8'h00, 12'h000, 8'h44);
    send(`SCMH_MC_NEXT_PAUSE, 8'h00, 12'h000, 8'h09);
    send(`SCMH_MC_NEXT_RST_BUS, 8'h00, 12'h000, 8'h00);
    boundary();
    repeat (3) begin
      hov = hov | (ho.valid === 1'b1 && ho.la === 8'h44);
      pz = pz | (pause === 1'b1);
      step(1);
    end
    check({hov, pz, rt, enum_st, la}, {1'b1, 1'b1, 8'h09, 1'b0, 8'h00});
    send(`SCMH_MC_BEGIN_RECFG, 8'h00, 12'h000, 8'h00);
    send(`SCMH_MC_NEXT_SHUTDOWN, 8'h00, 12'h000, 8'h00);
    boundary();
    step(2);
    send(`SCMH_MC_REQ_INFO, 8'h13, `SCMH_INFO_EVT_EC, 8'h00);
    step(6);
    check({shut, tx.valid}, {1'b1, 1'b0});
    $display("test ctrl done");
  endtask : t_ctrl
  initial begin
    step(10);
    nrst = 1'b1;
    t_enum();
    t_info();
    t_value();
    t_recfg();
    t_reset();
    t_ctrl();
    wrap_up();
  end
endmodule : scmh_core_msg_handler_tb
`default_nettype wire

//--- testbench/scmh_mgr_model.sv
// Purpose: bus manager and active framer stand-in
// Assumes: replies are taken on the core clock
// Notes: bus clock runs free while the bus is framed
`timescale 1ns/100ps
`default_nettype none
module scmh_mgr_model (
  input wire logic clk_in,
  input wire logic tx_valid_in,
  input wire logic [3:0] lat_in,
  output logic bus_clk_out,
  output logic tx_ready_out
);
  logic [3:0] wait_cnt;
  // sole manager and framer on this bus, 80 ns cell clock
  initial bus_clk_out = 1'b0;
  always #40 bus_clk_out = ~bus_clk_out;
  initial begin
    tx_ready_out = 1'b0;
    wait_cnt = 4'h0;
  end
  // a nonzero latency makes the device hold its reply and stall requests
  always @(posedge clk_in) begin
    if (tx_ready_out) begin
      tx_ready_out <= #1 1'b0;
      wait_cnt <= 4'h0;
    end else if (tx_valid_in) begin
      if (wait_cnt >= lat_in) begin
        tx_ready_out <= #1 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : scmh_mgr_model
`default_nettype wire
